//--- logic/act_conv_timing.sv
// Conversion timing control: master clock source, modulator clock,
// line-rejection select, conversion scheduling and result hand-off.
// Assumes a serial decoder on clk that pulses the command edges, and a
// filter datapath that presents its result on filt_result.
//
// Behaviour
// - Normal and duty-cycle modes: modulator clock is master clock over 16.
// - Turbo mode: modulator clock is master clock over 8.
// - Master clock comes from internal oscillator or external pin, 4.096MHz.
// - Filter settles in one conversion cycle at every data rate.
// - At 5 and 20 SPS a two-bit field picks 50, 60 or both.
// - Notches and data rates scale linearly with master clock.
// - Continuous period runs between consecutive ready falling edges.
// - First conversion starts 210 (or 114 turbo) master periods after command.
// - Single-shot time counts from command end to ready falling edge.
// - Internal oscillator adds wake-up, 50us normal or 25us turbo.
// - Oscillator wake starts on first serial rising edge of command.
// - Conversion waits until the oscillator is fully running.
// - Normal mode continuous periods per rate from fixed table.
// - Duty-cycle continuous periods from table; single-shot as normal mode except at rates 3 and 4.
// - Turbo continuous and single-shot times per rate from table.
// - Two external rising edges switch oscillator off until reset.
`timescale 1ns/1ps
`default_nettype none
`include "act_regs.svh"
module act_conv_timing import act_pkg::*; #(
    parameter int WAKE_NORM_CYC = `ACT_WAKE_NORM_CYC,
    parameter int WAKE_TURBO_CYC = `ACT_WAKE_TURBO_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_clk_pin,
    input wire logic reset_cmd,
    input wire logic cmd_first_rise,
    input wire logic cmd_last_fall,
    input wire logic [1:0] op_mode,
    input wire logic [2:0] data_rate,
    input wire logic continuous,
    input wire logic [1:0] line_reject,
    input wire logic [`ACT_DATA_W-1:0] filt_result,
    input wire logic rd_ready,
    output logic [`ACT_DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic result_ready_low,
    output logic modulator_clk,
    output logic [1:0] filt_line_sel,
    output logic ext_clk_active,
    output logic osc_running,
    output logic conv_busy
);
    localparam logic [4:0] OSC_DIV = 5'(`ACT_INT_OSC_DIV);

    act_state_type state_q;
    act_state_type state_d;
    logic ext_level;
    logic ext_prev_q;
    logic [1:0] ext_edges_q;
    logic ext_sel_q;
    logic osc_on_q;
    logic [12:0] wake_q;
    logic [4:0] osc_div_q;
    logic mclk_tick;
    logic ext_rise;
    logic osc_ready;
    logic turbo;
    logic [3:0] mod_div_q;
    logic mod_clk_q;
    logic [`ACT_CNT_W-1:0] cnt_q;
    logic [`ACT_CNT_W-1:0] cont_len;
    logic [`ACT_CNT_W-1:0] single_len;
    logic [`ACT_CNT_W-1:0] start_dly;
    logic [12:0] wake_len;
    logic conv_done;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [`ACT_DATA_W-1:0] fifo_out_data;
    logic push;
    logic pop;
    logic out_valid_q;
    logic [`ACT_DATA_W-1:0] out_data_q;
    logic drdy_low_q;
    logic [1:0] line_q;
    logic line_rate_ok;
    logic start_conv;
    logic load_cnt;
    logic busy_q;

    act_sync u_ext_sync (
        .clk(clk),
        .reset(reset),
        .pin(ext_clk_pin),
        .level(ext_level)
    );

    assign ext_rise = ext_level && !ext_prev_q;
    assign turbo = (op_mode == ACT_MODE_TURBO);
    assign mclk_tick = ext_sel_q ? ext_rise
                                 : (osc_on_q && osc_div_q == 5'h00);
    assign osc_ready = ext_sel_q || (osc_on_q && wake_q == 13'h0000);
    assign wake_len = turbo ? 13'(WAKE_TURBO_CYC) : 13'(WAKE_NORM_CYC);
    assign start_dly = turbo ? `ACT_CNT_W'(`ACT_START_DLY_TURBO)
                             : `ACT_CNT_W'(`ACT_START_DLY_NORM);
    assign conv_done = mclk_tick && cnt_q == `ACT_CNT_W'(1);
    assign push = (state_q == ACT_ST_STALL) && fifo_in_ready;
    assign pop = fifo_out_valid && (!out_valid_q || rd_ready);
    // A repeated command in the same state must still reload the count
    assign load_cnt = cmd_last_fall || (state_d != state_q);
    assign start_conv = (state_d == ACT_ST_CONV || state_d == ACT_ST_DELAY)
                        && load_cnt;
    // rejection only at the lowest rates
    assign line_rate_ok = (op_mode == ACT_MODE_NORMAL &&
                           data_rate == `ACT_RATE_20SPS) ||
                          (op_mode == ACT_MODE_DUTY &&
                           data_rate == `ACT_RATE_5SPS);

    always_comb
    begin
        cont_len = `ACT_CNT_W'(205439);
        single_len = `ACT_CNT_W'(206262);
        case ({op_mode, data_rate})
            5'h00: begin cont_len = 20'd205439; single_len = 20'd206262; end
            5'h01: begin cont_len = 20'd102719; single_len = 20'd103543; end
            5'h02: begin cont_len = 20'd54784; single_len = 20'd55607; end
            5'h03: begin cont_len = 20'd27390; single_len = 20'd28217; end
            5'h04: begin cont_len = 20'd13693; single_len = 20'd14516; end
            5'h05: begin cont_len = 20'd6824; single_len = 20'd7696; end
            5'h06: begin cont_len = 20'd4071; single_len = 20'd4944; end
            5'h08: begin cont_len = 20'd819597; single_len = 20'd206262; end
            5'h09: begin cont_len = 20'd409887; single_len = 20'd103543; end
            5'h0a: begin cont_len = 20'd218735; single_len = 20'd55607; end
            5'h0b: begin cont_len = 20'd109519; single_len = 20'd28213; end
            5'h0c: begin cont_len = 20'd54895; single_len = 20'd14520; end
            5'h0d: begin cont_len = 20'd27591; single_len = 20'd7696; end
            5'h0e: begin cont_len = 20'd16663; single_len = 20'd4944; end
            5'h10: begin cont_len = 20'd102719; single_len = 20'd103166; end
            5'h11: begin cont_len = 20'd51360; single_len = 20'd51806; end
            5'h12: begin cont_len = 20'd27390; single_len = 20'd27841; end
            5'h13: begin cont_len = 20'd13693; single_len = 20'd14143; end
            5'h14: begin cont_len = 20'd6849; single_len = 20'd7295; end
            5'h15: begin cont_len = 20'd3412; single_len = 20'd3883; end
            5'h16: begin cont_len = 20'd2036; single_len = 20'd2507; end
            default: ;
        endcase
    end

    // A new command always restarts the schedule, even mid-conversion
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ACT_ST_IDLE: ;
            ACT_ST_WAKE:
                if (osc_ready)
                    state_d = continuous ? ACT_ST_DELAY : ACT_ST_CONV;
            ACT_ST_DELAY:
                if (conv_done)
                    state_d = ACT_ST_CONV;
            ACT_ST_CONV:
                if (conv_done)
                    state_d = ACT_ST_STALL;
            // Full FIFO stalls the schedule rather than dropping results
            ACT_ST_STALL:
                if (fifo_in_ready)
                    state_d = continuous ? ACT_ST_CONV : ACT_ST_IDLE;
            default: state_d = ACT_ST_IDLE;
        endcase
        if (cmd_last_fall)
            state_d = osc_ready ? (continuous ? ACT_ST_DELAY : ACT_ST_CONV)
                                : ACT_ST_WAKE;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= ACT_ST_IDLE;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            busy_q <= (state_d != ACT_ST_IDLE);
        end
    end

    // single-shot length counted in master periods
    // continuous period reloads back to back
    // all counts in this block are in master periods
    always_ff @(posedge clk)
    begin
        if (reset)
            cnt_q <= '0;
        else if (load_cnt && state_d == ACT_ST_DELAY)
            cnt_q <= start_dly;
        else if (load_cnt && state_d == ACT_ST_CONV)
            cnt_q <= continuous ? cont_len : single_len;
        else if (mclk_tick && cnt_q != '0)
            cnt_q <= cnt_q - `ACT_CNT_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (reset || reset_cmd)
        begin
            ext_prev_q <= 1'b0;
            ext_edges_q <= 2'h0;
            ext_sel_q <= 1'b0;
        end
        else
        begin
            ext_prev_q <= ext_level;
            if (ext_rise && ext_edges_q != 2'(`ACT_EXT_EDGES))
                ext_edges_q <= ext_edges_q + 2'h1;
            if (ext_edges_q == 2'(`ACT_EXT_EDGES))
                ext_sel_q <= 1'b1;
        end
    end

    // wake on first serial edge
    // Single-shot with internal clock sleeps the oscillator between results
    always_ff @(posedge clk)
    begin
        if (reset || reset_cmd)
        begin
            osc_on_q <= 1'b1;
            wake_q <= 13'h0000;
        end
        else if (ext_sel_q)
            osc_on_q <= 1'b0;
        else if (cmd_first_rise && !osc_on_q)
        begin
            osc_on_q <= 1'b1;
            wake_q <= wake_len;
        end
        else if (push && !continuous)
            osc_on_q <= 1'b0;
        else if (wake_q != 13'h0000)
            wake_q <= wake_q - 13'h0001;
    end

    always_ff @(posedge clk)
    begin
        if (reset || !osc_on_q || osc_div_q == OSC_DIV - 5'h01)
            osc_div_q <= 5'h00;
        else
            osc_div_q <= osc_div_q + 5'h01;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mod_div_q <= 4'h0;
            mod_clk_q <= 1'b0;
        end
        else if (mclk_tick)
        begin
            mod_div_q <= mod_div_q + 4'h1;
            // At or above the limit, so a mode switch cannot stretch a half
            if (mod_div_q >= (turbo ? 4'(`ACT_MOD_DIV_TURBO / 2 - 1)
                                    : 4'(`ACT_MOD_DIV_NORM / 2 - 1)))
            begin
                mod_div_q <= 4'h0;
                mod_clk_q <= !mod_clk_q;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            line_q <= ACT_LINE_NONE;
        else
            line_q <= line_rate_ok ? line_reject : ACT_LINE_NONE;
    end

    act_fifo #(
        .WIDTH(`ACT_DATA_W),
        .DEPTH(`ACT_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(state_q == ACT_ST_STALL),
        .in_ready(fifo_in_ready),
        .in_data(filt_result),
        .out_valid(fifo_out_valid),
        .out_ready(!out_valid_q || rd_ready),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end
        else if (pop)
        begin
            out_valid_q <= 1'b1;
            out_data_q <= fifo_out_data;
        end
        else if (rd_ready)
            out_valid_q <= 1'b0;
    end

    // ready low on result, high on read or start
    always_ff @(posedge clk)
    begin
        if (reset)
            drdy_low_q <= 1'b1;
        else if (push)
            drdy_low_q <= 1'b0;
        else if ((out_valid_q && rd_ready) || start_conv)
            drdy_low_q <= 1'b1;
    end

    assign rd_data = out_data_q;
    assign rd_valid = out_valid_q;
    assign result_ready_low = drdy_low_q;
    assign modulator_clk = mod_clk_q;
    assign filt_line_sel = line_q;
    assign ext_clk_active = ext_sel_q;
    assign osc_running = osc_on_q;
    assign conv_busy = busy_q;
endmodule
`default_nettype wire

//--- logic/act_fifo.sv
// Flip-flop FIFO for conversion results, width and depth as parameters.
// Depth must be a power of two; reads and writes on the same clock.
`timescale 1ns/1ps
`default_nettype none
module act_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q + AW'(push);
            rd_ptr_q <= rd_ptr_q + AW'(pop);
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

//--- logic/act_pkg.sv
// Types shared by the conversion timing block.
// Needs nothing from its surroundings.
package act_pkg;
    typedef enum logic [1:0] {
        ACT_MODE_NORMAL,
        ACT_MODE_DUTY,
        ACT_MODE_TURBO
    } act_mode_type;

    typedef enum logic [1:0] {
        ACT_LINE_NONE,
        ACT_LINE_BOTH,
        ACT_LINE_50,
        ACT_LINE_60
    } act_line_type;

    typedef enum {
        ACT_ST_IDLE,
        ACT_ST_WAKE,
        ACT_ST_DELAY,
        ACT_ST_CONV,
        ACT_ST_STALL
    } act_state_type;
endpackage

//--- logic/act_regs.svh
// Timing and encoding constants for the conversion timing block.
// Assumes a 100 MHz system clock and a 4.096 MHz nominal master clock.
`ifndef ACT_REGS_SVH
`define ACT_REGS_SVH

`define ACT_SYS_CLK_HZ 100000000
`define ACT_MCLK_HZ 4096000
`define ACT_INT_OSC_DIV (`ACT_SYS_CLK_HZ / `ACT_MCLK_HZ)
`define ACT_MOD_DIV_NORM 16
`define ACT_MOD_DIV_TURBO 8
`define ACT_START_DLY_NORM 210
`define ACT_START_DLY_TURBO 114
`define ACT_WAKE_NORM_US 50
`define ACT_WAKE_TURBO_US 25
`define ACT_WAKE_NORM_CYC (`ACT_WAKE_NORM_US * (`ACT_SYS_CLK_HZ / 1000000))
`define ACT_WAKE_TURBO_CYC (`ACT_WAKE_TURBO_US * (`ACT_SYS_CLK_HZ / 1000000))
`define ACT_EXT_EDGES 2
`define ACT_FIFO_DEPTH 8
`define ACT_DATA_W 16
`define ACT_CNT_W 20
`define ACT_RATE_20SPS 3'h0
`define ACT_RATE_5SPS 3'h0

`endif

//--- logic/act_sync.sv
// Three-stage synchroniser for one pin; output changes once stages 2 and 3
// agree. Assumes the pin is slower than a third of clk.
`timescale 1ns/1ps
`default_nettype none
module act_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    assign level = level_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                level_q <= s3_q;
        end
    end
endmodule
`default_nettype wire

//--- tb/act_conv_timing_props.sv
// Checker for the conversion timing block, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "act_regs.svh"
module act_conv_timing_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic reset_cmd,
    input wire logic cmd_last_fall,
    input wire logic [1:0] op_mode,
    input wire logic [2:0] data_rate,
    input wire logic [1:0] line_reject,
    input wire logic rd_ready,
    input wire logic [`ACT_DATA_W-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic result_ready_low,
    input wire logic modulator_clk,
    input wire logic [1:0] filt_line_sel,
    input wire logic ext_clk_active,
    input wire logic osc_running,
    input wire logic conv_busy
);
    logic mod_q;
    logic [8:0] half_q;
    logic [8:0] half_d;
    logic rej_rate;
    assign rej_rate = (op_mode == 2'h0 || op_mode == 2'h1) && data_rate == 3'h0;
    // Saturates so a stuck modulator clock cannot wrap back under the bound
    // Restarts while the oscillator sleeps, so a wake does not see a stale span
    assign half_d = (reset || !osc_running || modulator_clk != mod_q) ? 9'h0 :
        (half_q == 9'h1ff ? half_q : half_q + 9'h1);
    always_ff @(posedge clk)
    begin
        mod_q <= modulator_clk;
        half_q <= half_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_reset_idle: assert property (disable iff (1'b0) reset |=>
        result_ready_low && !rd_valid && !conv_busy && !ext_clk_active)
        else $error("outputs not idle after reset");
    chk_cmd_busy: assert property (cmd_last_fall |=> conv_busy)
        else $error("command did not start scheduling");
    chk_line_pass: assert property (rej_rate |=>
        filt_line_sel == $past(line_reject))
        else $error("line select not passed at slow rate");
    chk_line_off: assert property (!rej_rate |=> filt_line_sel == 2'h0)
        else $error("line select active at other rate");
    chk_ext_latch: assert property (ext_clk_active && !reset_cmd |=>
        ext_clk_active) else $error("external selection lost");
    chk_cmd_drop: assert property (reset_cmd |=> !ext_clk_active)
        else $error("reset command kept external clock");
    chk_osc_off: assert property (ext_clk_active && $past(ext_clk_active)
        |-> !osc_running) else $error("oscillator on with external clock");
    chk_push_valid: assert property ($fell(result_ready_low) |->
        ##[0:2] rd_valid) else $error("ready fell without a result");
    chk_hold_data: assert property (rd_valid && !rd_ready |=>
        rd_valid && $stable(rd_data)) else $error("result not held");
    chk_mod_half: assert property (osc_running && !ext_clk_active |->
        half_q < 9'd300) else $error("modulator clock too slow");
    cover property ($fell(result_ready_low));
    cover property ($rose(ext_clk_active));
    cover property (rd_valid && !rd_ready ##1 rd_ready);
endmodule
bind act_conv_timing act_conv_timing_props i_props (.clk(clk),
    .reset(reset), .reset_cmd(reset_cmd), .cmd_last_fall(cmd_last_fall),
    .op_mode(op_mode), .data_rate(data_rate), .line_reject(line_reject),
    .rd_ready(rd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .result_ready_low(result_ready_low), .modulator_clk(modulator_clk),
    .filt_line_sel(filt_line_sel), .ext_clk_active(ext_clk_active),
    .osc_running(osc_running), .conv_busy(conv_busy));
`default_nettype wire

//--- tb/act_host_model.sv
// Host side: sends begin-conversion commands, reads results, drives the
// external clock pin. Assumes the system clock clk.
`timescale 1ns/1ps
`default_nettype none
module act_host_model #(
    parameter real EXT_HALF_NS = 122.07,
    parameter int GAP = 12
) (
    input wire logic clk,
    input wire logic start,
    input wire logic stall,
    input wire logic ext_en,
    output logic cmd_first_rise,
    output logic cmd_last_fall,
    output logic rd_ready,
    output logic ext_clk_pin
);
    int gap_q = 0;
    initial
    begin
        ext_clk_pin = 1'b0;
        #3.3;
        forever
        begin
            #(EXT_HALF_NS);
            // nominal clock, pin grounded while unused
            ext_clk_pin = ext_en ? ~ext_clk_pin : 1'b0;
        end
    end
    always @(posedge clk)
    begin
        cmd_first_rise <= start;
        cmd_last_fall <= (gap_q == 1);
        gap_q <= start ? GAP : (gap_q > 0 ? gap_q - 1 : 0);
        rd_ready <= !stall;
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the conversion timing block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import act_pkg::*;
    localparam int TK = 8;
    logic clk, reset, reset_cmd, start, stall, ext_en, continuous;
    logic cfr, clf, rd_ready, ext_pin, rd_valid, rrl, mod_clk, ext_act;
    logic osc, busy;
    logic [1:0] op_mode, line_reject, sel;
    logic [2:0] data_rate;
    logic [15:0] filt_result, rd_data;
    logic [31:0] seed = 32'h0001390a;
    int cyc = 0;
    int fail_count = 0;
    int cmp_count = 0;
    act_conv_timing #(.WAKE_NORM_CYC(20), .WAKE_TURBO_CYC(10))
    i_act_conv_timing (.clk(clk), .reset(reset), .ext_clk_pin(ext_pin),
        .reset_cmd(reset_cmd), .cmd_first_rise(cfr), .cmd_last_fall(clf),
        .op_mode(op_mode), .data_rate(data_rate), .continuous(continuous),
        .line_reject(line_reject), .filt_result(filt_result),
        .rd_ready(rd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .result_ready_low(rrl), .modulator_clk(mod_clk),
        .filt_line_sel(sel), .ext_clk_active(ext_act),
        .osc_running(osc), .conv_busy(busy));
    act_host_model #(.EXT_HALF_NS(40.0)) i_act_host_model (.clk(clk),
        .start(start), .stall(stall), .ext_en(ext_en), .cmd_first_rise(cfr),
        .cmd_last_fall(clf), .rd_ready(rd_ready), .ext_clk_pin(ext_pin));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Jitter of the pin synchroniser is forgiven within two ticks
    function automatic logic [31:0] near(input int n, input int e);
        return (n >= e - 2 * TK && n <= e + 2 * TK) ? e : n;
    endfunction
    function automatic logic sig(input int w);
        case (w)
            0: return mod_clk;
            1: return rrl;
            2: return rd_valid;
            3: return clf;
            default: return ext_act;
        endcase
    endfunction
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", name, exp, seen);
        end
    endtask
    task automatic wait_sig(input int w, input logic lvl, input int lim);
        int k;
        k = 0;
        while (sig(w) !== lvl && k < lim)
        begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic mod_period(output int n);
        int t0;
        wait_sig(0, 1'b0, 999);
        wait_sig(0, 1'b1, 999);
        t0 = cyc;
        wait_sig(0, 1'b0, 999);
        wait_sig(0, 1'b1, 999);
        n = cyc - t0;
    endtask
    task automatic command(output int t0);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wait_sig(3, 1'b1, 50);
        t0 = cyc;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    initial
    begin
        #1000000;
        fail_count++;
        print_verdict();
    end
    initial
    begin
        int n, t0, i;
        logic [2:0] r;
        logic [15:0] v;
        {reset, reset_cmd, start, stall, ext_en, continuous} = 6'h25;
        {op_mode, line_reject, data_rate, filt_result} = '0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check("idle", {rd_valid, rrl, mod_clk, sel, ext_act, osc, busy}, 8'h42);
        for (i = 0; i < 24; i++)
        begin
            r = (i < 12) ? 3'h0 : 3'(rnd() % 7);
            op_mode <= 2'(i % 3);
            data_rate <= r;
            line_reject <= 2'((i / 3) % 4);
            repeat (3) @(posedge clk);
            check("line_sel", sel, (i % 3 < 2 && r == 0) ? (i / 3) % 4 : 0);
        end
        op_mode <= 2'h0;
        mod_period(n);
        check("mod_norm", n, 384);
        op_mode <= 2'h2;
        mod_period(n);
        check("mod_turbo", n, 192);
        ext_en <= 1'b1;
        wait_sig(4, 1'b1, 200);
        repeat (2) @(posedge clk);
        check("ext_sel", {ext_act, osc}, 2'h2);
        mod_period(n);
        check("mod_ext_turbo", n, 8 * TK);
        op_mode <= 2'h0;
        mod_period(n);
        check("mod_ext_norm", n, 16 * TK);
        op_mode <= 2'h2;
        data_rate <= 3'h6;
        v = 16'(rnd());
        filt_result <= v;
        command(t0);
        wait_sig(1, 1'b0, 40000);
        check("cont_first", near(cyc - t0, 2150 * TK), 2150 * TK);
        t0 = cyc;
        filt_result <= 16'(rnd());
        repeat (20) @(posedge clk);
        check("stall_hold", {rd_valid, rrl, rd_data}, {2'h2, v});
        v = filt_result;
        stall <= 1'b0;
        wait_sig(1, 1'b1, 10);
        check("read_clear", rrl, 1'b1);
        wait_sig(1, 1'b0, 40000);
        check("cont_period", near(cyc - t0, 2036 * TK), 2036 * TK);
        wait_sig(2, 1'b1, 5);
        check("cont_data", rd_data, v);
        wait_sig(1, 1'b1, 10);
        continuous <= 1'b0;
        v = 16'(rnd());
        filt_result <= v;
        command(t0);
        wait_sig(1, 1'b0, 40000);
        check("single", near(cyc - t0, 2507 * TK), 2507 * TK);
        wait_sig(2, 1'b1, 5);
        check("single_data", rd_data, v);
        continuous <= 1'b1;
        reset_cmd <= 1'b1;
        ext_en <= 1'b0;
        @(posedge clk);
        reset_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        check("osc_back", {ext_act, osc}, 2'h1);
        mod_period(n);
        mod_period(n);
        check("mod_int_again", n, 192);
        print_verdict();
    end
endmodule
`default_nettype wire
